// *** verilog/atrtc_top.sv ***
`timescale 1ns/100ps
// Functional notes
// - 32-bit prescaler drives 32-bit up-counter
// - Prescaler clock chosen among five sources
// - Periodic events from chosen prescaler bits
// - Alarm fires when counter equals alarm
// - Overflow raises interrupt and event
// - Optional counter reset on any alarm
// - Keeps counting while core powered off
// - Wakes system on alarm, tick, overflow
// - Runs when enabled, source allowed and not frozen in debug
// - Separate bus clock, gateable by power manager
// - Shutdown allows only crystal and 1 kHz
// - 1 kHz needs crystal mode and enable
// - Freeze in debug unless both bits set
// - Optional calendar mode instead of binary
// - Binary counter wraps to zero, sets overflow
// - Counter steps on selected prescaler bit rise
// - Periodic tick on interval-select bit rise
// - Clear-on-alarm match clears counter, sets overflow
module atrtc_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Clock sources as level inputs
    input wire logic [4:0] src_clk_i,
    input wire logic [2:0] src_select_i,
    input wire logic crystal_mode_i,
    input wire logic one_khz_enable_i,
    // Power and debug
    input wire logic shutdown_i,
    input wire logic bus_clk_en_i,
    input wire logic debug_halt_i,
    input wire logic run_in_debug_i,
    input wire logic periph_debug_bits_i,
    // Configuration, written from the bus domain
    input wire atrtc_pkg::atrtc_ctrl_s ctrl_i,
    input wire logic [atrtc_pkg::NUM_PER*atrtc_pkg::SEL_W-1:0] interval_select_i,
    input wire logic [atrtc_pkg::NUM_ALARM*atrtc_pkg::CNT_W-1:0] alarm_value_i,
    input wire logic [atrtc_pkg::CNT_W-1:0] cnt_wdata_i,
    input wire logic cnt_write_i,
    input wire logic cfg_load_i,
    input wire atrtc_pkg::atrtc_evt_s status_clear_i,
    input wire atrtc_pkg::atrtc_evt_s irq_mask_i,
    input wire atrtc_pkg::atrtc_evt_s wake_mask_i,
    // Status and events
    output atrtc_pkg::atrtc_evt_s event_o,
    output atrtc_pkg::atrtc_evt_s status_o,
    output logic [atrtc_pkg::CNT_W-1:0] count_o,
    output logic irq_o,
    output logic wake_o,
    output logic busy_o,
    output logic clk_ok_o
);
    import atrtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Source clock select and three-stage sampling
    logic src_allowed;
    logic src_level;
    logic [2:0] src_sync;
    always_comb begin
        src_allowed = 1'b1;
        if (src_select_i == SRC_ONE_KHZ && !(crystal_mode_i && one_khz_enable_i)) begin
            src_allowed = 1'b0;
        end
        if (shutdown_i && src_select_i != SRC_CRYSTAL_32K && src_select_i != SRC_ONE_KHZ) begin
            src_allowed = 1'b0;
        end
        // Codes past the last source have no clock behind them
        if (src_select_i > SRC_ONE_KHZ) begin
            src_allowed = 1'b0;
        end
        src_level = (src_select_i <= SRC_ONE_KHZ) ? src_clk_i[src_select_i] : 1'b0;
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            src_sync <= 3'h0;
        end else begin
            src_sync <= {src_sync[1:0], src_level};
        end
    end
    // Rise counted only once stages two and three agree
    logic src_state;
    logic next_src_state;
    logic src_rise;
    always_comb begin
        next_src_state = src_state;
        if (src_sync[1] == src_sync[2]) begin
            next_src_state = src_sync[2];
        end
        src_rise = next_src_state && !src_state;
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            src_state <= 1'b0;
        end else begin
            src_state <= next_src_state;
        end
    end
    assign clk_ok_o = src_allowed;

    ////////////////////////////////////////////////////////////////////////
    // Configuration handshake: bus side requests, timer side accepts
    atrtc_hs_e hs;
    atrtc_hs_e next_hs;
    atrtc_ctrl_s ctrl;
    atrtc_ctrl_s next_ctrl;
    logic [NUM_PER*SEL_W-1:0] ivsel;
    logic [NUM_PER*SEL_W-1:0] next_ivsel;
    logic [NUM_ALARM*CNT_W-1:0] alarm;
    logic [NUM_ALARM*CNT_W-1:0] next_alarm;
    logic [CNT_W-1:0] cnt_load;
    logic [CNT_W-1:0] next_cnt_load;
    logic cnt_load_pend;
    logic next_cnt_load_pend;
    logic apply;
    always_comb begin
        next_hs = hs;
        next_ctrl = ctrl;
        next_ivsel = ivsel;
        next_alarm = alarm;
        next_cnt_load = cnt_load;
        next_cnt_load_pend = cnt_load_pend;
        apply = 1'b0;
        case (hs)
            ATRTC_IDLE: begin
                if ((cfg_load_i || cnt_write_i) && bus_clk_en_i) begin
                    next_hs = ATRTC_REQ;
                    next_ctrl = ctrl_i;
                    next_ivsel = interval_select_i;
                    next_alarm = alarm_value_i;
                    next_cnt_load = cnt_wdata_i;
                    next_cnt_load_pend = cnt_write_i;
                end
            end
            ATRTC_REQ: begin
                next_hs = ATRTC_ACK;
            end
            ATRTC_ACK: begin
                apply = 1'b1;
                next_cnt_load_pend = 1'b0;
                next_hs = ATRTC_IDLE;
            end
            default: begin
                next_hs = ATRTC_IDLE;
            end
        endcase
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hs <= ATRTC_IDLE;
            ctrl <= '0;
            ivsel <= '0;
            alarm <= '0;
            cnt_load <= CNT_ZERO;
            cnt_load_pend <= 1'b0;
        end else begin
            hs <= next_hs;
            ctrl <= next_ctrl;
            ivsel <= next_ivsel;
            alarm <= next_alarm;
            cnt_load <= next_cnt_load;
            cnt_load_pend <= next_cnt_load_pend;
        end
    end
    assign busy_o = (hs != ATRTC_IDLE);

    // Active copy only changes at the handshake's end
    atrtc_ctrl_s act;
    logic [NUM_PER*SEL_W-1:0] act_ivsel;
    logic [NUM_ALARM*CNT_W-1:0] act_alarm;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            act <= '0;
            act_ivsel <= '0;
            act_alarm <= '0;
        end else if (apply) begin
            act <= ctrl;
            act_ivsel <= ivsel;
            act_alarm <= alarm;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and counter
    logic frozen;
    logic run;
    logic [CNT_W-1:0] prsc;
    logic [CNT_W-1:0] next_prsc;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic cnt_rise;
    logic [NUM_ALARM-1:0] match;
    atrtc_evt_s evt;
    // Debug halt freezes the timer unless both debug bits are set; shutdown stops it only when the selected source is not allowed
    assign frozen = debug_halt_i && !(run_in_debug_i && periph_debug_bits_i);
    assign run = act.enable && src_allowed && !frozen;

    always_comb begin
        next_prsc = prsc;
        if (apply && ctrl.prescaler_clear) begin
            next_prsc = PRSC_RESET;
        end else if (run && src_rise) begin
            next_prsc = prsc + 32'h00000001;
        end
    end

    genvar g;
    logic [NUM_PER-1:0] per_rise;
    generate
        for (g = 0; g < NUM_PER; g = g + 1) begin : g_per
            logic [SEL_W-1:0] sel;
            assign sel = act_ivsel[g*SEL_W +: SEL_W];
            assign per_rise[g] = run && next_prsc[sel] && !prsc[sel];
        end
        for (g = 0; g < NUM_ALARM; g = g + 1) begin : g_alarm
            assign match[g] = act.enable && (cnt == act_alarm[g*CNT_W +: CNT_W]);
        end
    endgenerate

    assign cnt_rise = run && next_prsc[act.prescale_select] && !prsc[act.prescale_select];

    // Calendar increment: sec, min, hour, day, month, year
    function automatic logic [CNT_W-1:0] cal_step(input logic [CNT_W-1:0] v);
        logic [5:0] s;
        logic [5:0] mi;
        logic [4:0] h;
        logic [4:0] d;
        logic [3:0] mo;
        logic [5:0] y;
        logic [4:0] dmax;
        s = v[CAL_SEC_LSB +: 6];
        mi = v[CAL_MIN_LSB +: 6];
        h = v[CAL_HOUR_LSB +: 5];
        d = v[CAL_DAY_LSB +: 5];
        mo = v[CAL_MON_LSB +: 4];
        y = v[CAL_YEAR_LSB +: 6];
        case (mo)
            4'h2: dmax = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: dmax = 5'h1e;
            default: dmax = 5'h1f;
        endcase
        if (s != CAL_SEC_MAX) begin
            s = s + 6'h01;
        end else begin
            s = 6'h00;
            if (mi != CAL_MIN_MAX) begin
                mi = mi + 6'h01;
            end else begin
                mi = 6'h00;
                if (h != CAL_HOUR_MAX) begin
                    h = h + 5'h01;
                end else begin
                    h = 5'h00;
                    if (d < dmax) begin
                        d = d + 5'h01;
                    end else begin
                        d = 5'h01;
                        if (mo < CAL_MON_MAX) begin
                            mo = mo + 4'h1;
                        end else begin
                            mo = 4'h1;
                            y = y + 6'h01;
                        end
                    end
                end
            end
        end
        return {y, mo, d, h, mi, s};
    endfunction

    always_comb begin
        next_cnt = cnt;
        evt = '0;
        evt.periodic = per_rise;
        if (cnt_rise) begin
            evt.alarm = match;
            if (|(match & act.clear_on_alarm)) begin
                next_cnt = CNT_ZERO;
                evt.overflow = 1'b1;
            end else if (act.calendar) begin
                next_cnt = cal_step(cnt);
            end else begin
                next_cnt = cnt + 32'h00000001;
                evt.overflow = (cnt == CNT_TOP);
            end
        end
        if (apply && cnt_load_pend) begin
            next_cnt = cnt_load;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prsc <= PRSC_RESET;
            cnt <= CNT_ZERO;
        end else begin
            prsc <= next_prsc;
            cnt <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status, events, interrupt and wake
    atrtc_evt_s stat;
    atrtc_evt_s next_stat;
    // Set wins over a same-cycle clear
    assign next_stat = (stat & ~status_clear_i) | evt;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            stat <= '0;
            event_o <= '0;
            count_o <= CNT_ZERO;
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            stat <= next_stat;
            event_o <= evt;
            count_o <= next_cnt;
            irq_o <= |(next_stat & irq_mask_i);
            wake_o <= |(next_stat & wake_mask_i);
        end
    end
    assign status_o = stat;

endmodule

// *** verilog/atrtc_pkg.sv ***
package atrtc_pkg;

    // Clock source codes
    localparam logic [2:0] SRC_SYSTEM_RC = 3'h0;
    localparam logic [2:0] SRC_CRYSTAL_32K = 3'h1;
    localparam logic [2:0] SRC_BUS_CLOCK = 3'h2;
    localparam logic [2:0] SRC_GENERIC = 3'h3;
    localparam logic [2:0] SRC_ONE_KHZ = 3'h4;

    localparam int CNT_W = 32;
    localparam int SEL_W = 5;
    localparam int NUM_PER = 2;
    localparam int NUM_ALARM = 2;

    localparam logic [31:0] CNT_TOP = 32'hffffffff;
    localparam logic [31:0] CNT_ZERO = 32'h00000000;
    localparam logic [31:0] PRSC_RESET = 32'h00000000;
    localparam logic [4:0] PSEL_RESET = 5'h00;

    // Calendar field positions
    localparam int CAL_SEC_LSB = 0;
    localparam int CAL_MIN_LSB = 6;
    localparam int CAL_HOUR_LSB = 12;
    localparam int CAL_DAY_LSB = 17;
    localparam int CAL_MON_LSB = 22;
    localparam int CAL_YEAR_LSB = 26;
    localparam logic [5:0] CAL_SEC_MAX = 6'h3b;
    localparam logic [5:0] CAL_MIN_MAX = 6'h3b;
    localparam logic [4:0] CAL_HOUR_MAX = 5'h17;
    localparam logic [3:0] CAL_MON_MAX = 4'hc;

    typedef struct packed {
        logic enable;
        logic calendar;
        logic prescaler_clear;
        logic [SEL_W-1:0] prescale_select;
        logic [NUM_ALARM-1:0] clear_on_alarm;
    } atrtc_ctrl_s;

    typedef struct packed {
        logic overflow;
        logic [NUM_PER-1:0] periodic;
        logic [NUM_ALARM-1:0] alarm;
    } atrtc_evt_s;

    typedef enum logic [1:0] {
        ATRTC_IDLE,
        ATRTC_REQ,
        ATRTC_ACK
    } atrtc_hs_e;

endpackage

// *** tb/atrtc_top_chk.sv ***
`timescale 1ns/100ps
module atrtc_top_chk (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Source and power
    input wire logic [2:0] src_select_i,
    input wire logic crystal_mode_i,
    input wire logic one_khz_enable_i,
    input wire logic shutdown_i,
    input wire logic bus_clk_en_i,
    input wire logic debug_halt_i,
    input wire logic run_in_debug_i,
    input wire logic periph_debug_bits_i,
    // Requests and masks
    input wire logic cnt_write_i,
    input wire logic cfg_load_i,
    input wire atrtc_pkg::atrtc_ctrl_s ctrl_i,
    input wire atrtc_pkg::atrtc_evt_s irq_mask_i,
    input wire atrtc_pkg::atrtc_evt_s wake_mask_i,
    // Outputs watched
    input wire atrtc_pkg::atrtc_evt_s event_o,
    input wire atrtc_pkg::atrtc_evt_s status_o,
    input wire logic [atrtc_pkg::CNT_W-1:0] count_o,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic busy_o,
    input wire logic clk_ok_o
);
    import atrtc_pkg::*;
    logic req;
    logic frz;
    logic bad_src;
    assign req = (cfg_load_i || cnt_write_i) && !busy_o;
    assign frz = debug_halt_i && !(run_in_debug_i && periph_debug_bits_i);
    // Codes above four never tick
    assign bad_src = (src_select_i == SRC_ONE_KHZ && !(crystal_mode_i && one_khz_enable_i)) || src_select_i > 3'h4
        || (shutdown_i && src_select_i != SRC_CRYSTAL_32K && src_select_i != SRC_ONE_KHZ);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    AST_BUSY: assert property (req && bus_clk_en_i |=> busy_o [*2] ##1 !busy_o)
        else $error("busy span wrong");
    AST_BUS_OFF: assert property (req && !bus_clk_en_i |=> !busy_o)
        else $error("request taken with bus clock off");
    AST_STEP: assert property (count_o != $past(count_o) |->
        count_o == $past(count_o) + 32'h1 || count_o == CNT_ZERO || $past(busy_o) || ctrl_i.calendar)
        else $error("bad counter step");
    AST_WRAP: assert property (!$past(busy_o) && $past(count_o) == CNT_TOP && count_o == CNT_ZERO
        |-> ##[0:1] event_o.overflow) else $error("wrap without overflow event");
    AST_EVT_STS: assert property (|event_o |-> (status_o & event_o) == event_o)
        else $error("event without status");
    AST_IRQ: assert property ($stable(irq_mask_i) |-> irq_o == |(status_o & irq_mask_i))
        else $error("irq level wrong");
    AST_WAKE: assert property ($stable(wake_mask_i) |-> wake_o == |(status_o & wake_mask_i))
        else $error("wake level wrong");
    AST_FREEZE: assert property ((frz && !busy_o) [*6] |=> $stable(count_o))
        else $error("counter moved in debug halt");
    AST_CLK_OK: assert property (bad_src |-> !clk_ok_o)
        else $error("unusable source reported usable");
    cover property (event_o.overflow);
    cover property (|event_o.alarm);
    cover property (|event_o.periodic);
endmodule
bind atrtc_top atrtc_top_chk chk_u (.mclk_i, .rst_i, .src_select_i, .crystal_mode_i, .one_khz_enable_i,
    .shutdown_i, .bus_clk_en_i, .debug_halt_i, .run_in_debug_i, .periph_debug_bits_i, .cnt_write_i, .ctrl_i,
    .cfg_load_i, .irq_mask_i, .wake_mask_i, .event_o, .status_o, .count_o, .irq_o, .wake_o, .busy_o, .clk_ok_o);

// *** tb/atrtc_irq_model.sv ***
`timescale 1ns/100ps
module atrtc_irq_model (
    // Clock and control
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ack_en_i,
    // Timer side
    input wire logic irq_i,
    input wire atrtc_pkg::atrtc_evt_s status_i,
    output atrtc_pkg::atrtc_evt_s clear_o
);
    import atrtc_pkg::*;
    logic [1:0] lat = 2'h0;
    initial clear_o = '0;
    // Handler latency before the clear, as a service routine would take
    always @(posedge mclk_i) begin
        clear_o <= '0;
        if (rst_i || !ack_en_i || !irq_i) begin
            lat <= 2'h0;
        end else if (lat == 2'h2) begin
            clear_o <= status_i;
            lat <= 2'h0;
        end else begin
            lat <= lat + 2'h1;
        end
    end
endmodule

// *** tb/tb_atrtc_top.sv ***
`timescale 1ns/100ps
module tb_atrtc_top;
    import atrtc_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, ack_en = 1'b0;
    logic [4:0] src_clk_i = '0;
    logic [2:0] src_select_i = SRC_BUS_CLOCK;
    logic crystal_mode_i = 1'b1, one_khz_enable_i = 1'b1, shutdown_i = 1'b0, bus_clk_en_i = 1'b1;
    logic debug_halt_i = 1'b0, run_in_debug_i = 1'b0, periph_debug_bits_i = 1'b0;
    atrtc_ctrl_s ctrl_i = '0;
    logic [9:0] interval_select_i = 10'h041;
    logic [63:0] alarm_value_i = 64'h00001000_00001000;
    logic [31:0] cnt_wdata_i = '0, count_o, seed = 32'h1cbd56ea, last = '0, r;
    logic cnt_write_i = 1'b0, cfg_load_i = 1'b0, irq_o, wake_o, busy_o, clk_ok_o;
    atrtc_evt_s status_clear_i, irq_mask_i = 5'h10, wake_mask_i = 5'h13, event_o, status_o;
    int failures = 0, checked = 0, per0 = 0, per1 = 0;
    logic [31:0] exp_q[$];
    logic [6:0] tbl [11] = '{7'h07, 7'h17, 7'h27, 7'h37, 7'h47, 7'h2e, 7'h1f, 7'h4f, 7'h42, 7'h44, 7'h56};
    atrtc_top dut_u (.mclk_i, .rst_i, .src_clk_i, .src_select_i, .crystal_mode_i, .one_khz_enable_i,
        .shutdown_i, .bus_clk_en_i, .debug_halt_i, .run_in_debug_i, .periph_debug_bits_i, .ctrl_i,
        .interval_select_i, .alarm_value_i, .cnt_wdata_i, .cnt_write_i, .cfg_load_i, .status_clear_i,
        .irq_mask_i, .wake_mask_i, .event_o, .status_o, .count_o, .irq_o, .wake_o, .busy_o, .clk_ok_o);
    atrtc_irq_model irq_u (.mclk_i, .rst_i, .ack_en_i(ack_en), .irq_i(irq_o), .status_i(status_o),
        .clear_o(status_clear_i));
    initial forever #2 mclk_i = ~mclk_i;
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Calendar word built from the field positions
    function automatic logic [31:0] cal(input int y, input int mo, input int d, input int h, input int mi,
        input int s);
        return 32'((y << CAL_YEAR_LSB) | (mo << CAL_MON_LSB) | (d << CAL_DAY_LSB) | (h << CAL_HOUR_LSB)
            | (mi << CAL_MIN_LSB) | (s << CAL_SEC_LSB));
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // One source period is eight system cycles, well above the sampling delay
    task automatic pulse(input int n);
        repeat (n) begin
            src_clk_i = '1;
            tick(4);
            src_clk_i = '0;
            tick(4);
        end
    endtask
    // Write held a second cycle with other data: that copy must be refused
    task automatic cfg(input logic [4:0] ps, input logic [1:0] ca, input logic [31:0] v, input logic cm = 1'b0);
        ctrl_i = '{1'b1, cm, 1'b1, ps, ca};
        cnt_wdata_i = v;
        cnt_write_i = 1'b1;
        if (bus_clk_en_i) exp_q.push_back(v);
        tick(1);
        cnt_wdata_i = ~v;
        tick(1);
        cnt_write_i = 1'b0;
        tick(2);
    endtask
    task automatic ack();
        ack_en = 1'b1;
        tick(8);
        ack_en = 1'b0;
    endtask
    task automatic done(input int n);
        chk(32'(exp_q.size()), 32'h0);
        $display("test %0d done", n);
    endtask
    task automatic stop_test();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    always @(negedge mclk_i) begin
        if (!rst_i && count_o !== last) begin
            if (exp_q.size() == 0) chk(count_o, last);
            else chk(count_o, exp_q.pop_front());
        end
        last = count_o;
        if (event_o.periodic[0] === 1'b1) per0++;
        if (event_o.periodic[1] === 1'b1) per1++;
    end
    initial begin
        #20000;
        failures++;
        stop_test();
    end
    initial begin
        tick(3);
        rst_i = 1'b0;
        chk(count_o, CNT_ZERO);
        chk({27'h0, status_o}, 32'h0);
        cfg(5'h00, 2'h0, CNT_TOP - 32'h1);
        exp_q.push_back(CNT_TOP);
        exp_q.push_back(CNT_ZERO);
        pulse(4);
        chk({31'h0, status_o.overflow}, 32'h1);
        chk({30'h0, irq_o, wake_o}, 32'h3);
        ack();
        chk({26'h0, status_o, irq_o}, 32'h0);
        done(1);
        r = rnd() & 32'h7fffffff;
        alarm_value_i = {r + 32'h2, r + 32'h1};
        cfg(5'h00, 2'h2, r);
        exp_q.push_back(r + 32'h1);
        exp_q.push_back(r + 32'h2);
        exp_q.push_back(CNT_ZERO);
        pulse(6);
        chk({30'h0, status_o.alarm}, 32'h3);
        chk({31'h0, status_o.overflow}, 32'h1);
        ack();
        done(2);
        r = rnd() & 32'h7fffffff;
        cfg(5'h00, 2'h0, r);
        debug_halt_i = 1'b1;
        pulse(4);
        run_in_debug_i = 1'b1;
        pulse(2);
        periph_debug_bits_i = 1'b1;
        exp_q.push_back(r + 32'h1);
        pulse(2);
        {debug_halt_i, run_in_debug_i, periph_debug_bits_i} = 3'h0;
        bus_clk_en_i = 1'b0;
        cfg(5'h00, 2'h0, ~r);
        bus_clk_en_i = 1'b1;
        done(3);
        foreach (tbl[i]) begin
            r = rnd() & 32'h7fffffff;
            cfg(5'h00, 2'h0, r);
            {src_select_i, shutdown_i, crystal_mode_i, one_khz_enable_i} = tbl[i][6:1];
            if (tbl[i][0]) exp_q.push_back(r + 32'h1);
            pulse(2);
            chk({31'h0, clk_ok_o}, {31'h0, tbl[i][0]});
            {shutdown_i, crystal_mode_i, one_khz_enable_i} = 3'h3;
        end
        src_select_i = SRC_BUS_CLOCK;
        done(4);
        r = rnd() & 32'h7fffffff;
        cfg(5'h03, 2'h0, r);
        {per0, per1} = '0;
        exp_q.push_back(r + 32'h1);
        exp_q.push_back(r + 32'h2);
        pulse(7);
        chk(32'(exp_q.size()), 32'h2);
        pulse(1);
        chk(32'(exp_q.size()), 32'h1);
        pulse(16);
        chk(32'(per0), 32'h6);
        chk(32'(per1), 32'h3);
        done(5);
        // Leap day, plain month end and year end
        cfg(5'h00, 2'h0, cal(0, 2, 28, 23, 59, 59), 1'b1);
        exp_q.push_back(cal(0, 2, 29, 0, 0, 0));
        exp_q.push_back(cal(0, 2, 29, 0, 0, 1));
        pulse(4);
        cfg(5'h00, 2'h0, cal(1, 2, 28, 23, 59, 59), 1'b1);
        exp_q.push_back(cal(1, 3, 1, 0, 0, 0));
        pulse(2);
        cfg(5'h00, 2'h0, cal(1, 12, 31, 23, 59, 59), 1'b1);
        exp_q.push_back(cal(2, 1, 1, 0, 0, 0));
        pulse(2);
        done(6);
        // Reset in mid-run clears counter and status
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        chk(count_o, CNT_ZERO);
        chk({27'h0, status_o}, 32'h0);
        done(7);
        stop_test();
    end
endmodule
